// ===== core/digipot_control_pins.sv
`timescale 1ns/10ps
`default_nettype none
module digipot_control_pins
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_interface_select,
	input wire logic i_sclk,
	input wire logic i_sync_n,
	input wire logic i_sdi,
	input wire logic i_sdo_pin,
	input wire logic i_reset_n,
	input wire logic i_wp_n,
	input wire logic i_independent_gain_mode,
	input wire logic i_load_wiper_n,
	input wire logic [7:0] i_nvm_wiper,
	input wire logic [7:0] i_nvm_ab,
	input wire logic [7:0] i_nvm_wb,
	output logic o_sdo,
	output logic o_sdo_oe_n,
	output logic o_sda_oe_n,
	output logic [1:0] o_i2c_addr,
	output logic o_i2c_mode,
	output digipot_pkg::frame_s o_frame,
	output logic o_frame_valid,
	output digipot_pkg::status_s o_status,
	output logic [7:0] o_input_reg,
	output logic [7:0] o_ab_setting,
	output logic [7:0] o_wb_setting,
	output logic o_nvm_write
);
	import digipot_pkg::*;

	logic [6:0] pins_s;
	logic sclk_s;
	logic sync_n_s;
	logic sdi_s;
	logic sdo_pin_s;
	logic dis_s;
	logic reset_n_s;
	logic wp_n_s;
	logic ldw_n_s;

	// every pin but i_independent_gain_mode, i_nvm_wiper, i_nvm_ab and i_nvm_wb crosses two flops before any logic reads it
	digipot_sync #(.W(7)) u_sync_pins
	(
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async({i_sclk, i_sync_n, i_sdi, i_sdo_pin, i_interface_select,
			i_wp_n, i_load_wiper_n}),
		.o_sync(pins_s)
	);
	assign {sclk_s, sync_n_s, sdi_s, sdo_pin_s, dis_s, wp_n_s, ldw_n_s} =
		pins_s;

	digipot_sync #(.W(1)) u_sync_rst
	(
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_async(i_reset_n),
		.o_sync(reset_n_s)
	);

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_STORE = 2'b11
	} link_e;

	link_e state_r, state_nxt;
	logic sclk_d_r, sclk_d_nxt;
	logic sync_d_r, sync_d_nxt;
	logic ldw_d_r, ldw_d_nxt;
	logic rst_d_r, rst_d_nxt;
	logic [15:0] shift_r, shift_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic [24:0] store_cnt_r, store_cnt_nxt;
	logic [7:0] wiper_r, wiper_nxt;
	logic [7:0] input_r, input_nxt;
	logic [7:0] nvm_r, nvm_nxt;
	logic [7:0] ab_r, ab_nxt;
	logic [7:0] wb_r, wb_nxt;
	logic gain_r, gain_nxt;
	logic boot_r, boot_nxt;
	logic sdo_r, sdo_nxt;
	logic sdo_oe_n_r, sdo_oe_n_nxt;
	logic [1:0] addr_r, addr_nxt;
	logic mode_r, mode_nxt;
	frame_s frame_r, frame_nxt;
	logic fvalid_r, fvalid_nxt;
	logic nvm_wr_r, nvm_wr_nxt;

	logic sclk_fall;
	logic sclk_rise;
	logic frame_end;
	logic ldw_fall;
	logic rst_fall;
	logic spi_mode;
	frame_s rx;

	always_comb
	begin
		sclk_fall = sclk_d_r & ~sclk_s;
		sclk_rise = ~sclk_d_r & sclk_s;
		frame_end = ~sync_d_r & sync_n_s;
		ldw_fall = ldw_d_r & ~ldw_n_s;
		rst_fall = rst_d_r & ~reset_n_s;
		spi_mode = ~dis_s;
		rx = frame_s'(shift_r);
	end

	always_comb
	begin
		state_nxt = state_r;
		sclk_d_nxt = sclk_s;
		sync_d_nxt = sync_n_s;
		ldw_d_nxt = ldw_n_s;
		rst_d_nxt = reset_n_s;
		shift_nxt = shift_r;
		cnt_nxt = cnt_r;
		rd_nxt = rd_r;
		store_cnt_nxt = store_cnt_r;
		wiper_nxt = wiper_r;
		input_nxt = input_r;
		nvm_nxt = nvm_r;
		ab_nxt = ab_r;
		wb_nxt = wb_r;
		gain_nxt = gain_r;
		boot_nxt = 1'b0;
		sdo_nxt = sdo_r;
		sdo_oe_n_nxt = 1'b1;
		addr_nxt = addr_r;
		mode_nxt = dis_s;
		frame_nxt = frame_r;
		fvalid_nxt = 1'b0;
		nvm_wr_nxt = 1'b0;
		if (boot_r)
		begin
			nvm_nxt = i_nvm_wiper;
			wiper_nxt = i_nvm_wiper;
			// power-up strap of the gain mode, caught after reset release
			gain_nxt = i_independent_gain_mode;
			ab_nxt = i_nvm_ab;
			wb_nxt = i_nvm_wb;
		end
		if (dis_s)
		begin
			addr_nxt = {sdo_pin_s, sync_n_s};
		end
		case (state_r)
			ST_IDLE:
			begin
				cnt_nxt = CNT_ZERO;
				if (spi_mode && !sync_n_s)
				begin
					state_nxt = ST_SHIFT;
					rd_nxt = {8'h00, wiper_r};
				end
				else if (!spi_mode && sclk_fall)
				begin
					shift_nxt = {shift_r[14:0], sdi_s};
				end
			end
			ST_SHIFT:
			begin
				// open drain: drive only when the bit is low
				sdo_oe_n_nxt = sdo_r;
				if (sclk_rise)
				begin
					sdo_nxt = rd_r[15];
					rd_nxt = {rd_r[14:0], 1'b1};
				end
				if (sclk_fall && cnt_r != CNT_FULL)
				begin
					shift_nxt = {shift_r[14:0], sdi_s};
					cnt_nxt = cnt_r + 5'h01;
				end
				if (frame_end || !spi_mode)
				begin
					state_nxt = ST_IDLE;
					sdo_nxt = 1'b1;
					if (cnt_r == CNT_FULL && spi_mode)
					begin
						frame_nxt = rx;
						fvalid_nxt = 1'b1;
						if (wp_n_s)
						begin
							case (rx.ctrl)
								CMD_WR_WIPER: wiper_nxt = rx.data;
								CMD_WR_INPUT: input_nxt = rx.data;
								CMD_STORE:
								begin
									state_nxt = ST_STORE;
									store_cnt_nxt = 25'(STORE_CYCLES - 1);
									nvm_wr_nxt = 1'b1;
								end
								CMD_GAIN_OFF: gain_nxt = gain_r;
								default: wiper_nxt = wiper_r;
							endcase
						end
					end
				end
			end
			ST_STORE:
			begin
				// commands are ignored until the store completes
				if (store_cnt_r == 25'h0000000)
				begin
					state_nxt = ST_IDLE;
					nvm_nxt = wiper_r;
				end
				else
				begin
					store_cnt_nxt = store_cnt_r - 25'h0000001;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (ldw_fall && wp_n_s)
		begin
			wiper_nxt = input_r;
		end
		if (rst_fall)
		begin
			wiper_nxt = nvm_r;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= ST_IDLE;
			// idle level of the serial clock is high, so no false edge
			sclk_d_r <= 1'b1;
			sync_d_r <= 1'b1;
			ldw_d_r <= 1'b1;
			rst_d_r <= 1'b1;
			shift_r <= 16'h0000;
			cnt_r <= CNT_ZERO;
			rd_r <= 16'hFFFF;
			store_cnt_r <= 25'h0000000;
			wiper_r <= WIPER_RST;
			input_r <= INPUT_RST;
			nvm_r <= WIPER_RST;
			ab_r <= 8'h00;
			wb_r <= 8'h00;
			gain_r <= 1'b0;
			boot_r <= 1'b1;
			sdo_r <= 1'b1;
			sdo_oe_n_r <= 1'b1;
			addr_r <= 2'b00;
			mode_r <= 1'b0;
			frame_r <= '0;
			fvalid_r <= 1'b0;
			nvm_wr_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			sclk_d_r <= sclk_d_nxt;
			sync_d_r <= sync_d_nxt;
			ldw_d_r <= ldw_d_nxt;
			rst_d_r <= rst_d_nxt;
			shift_r <= shift_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			store_cnt_r <= store_cnt_nxt;
			wiper_r <= wiper_nxt;
			input_r <= input_nxt;
			nvm_r <= nvm_nxt;
			ab_r <= ab_nxt;
			wb_r <= wb_nxt;
			gain_r <= gain_nxt;
			boot_r <= boot_nxt;
			sdo_r <= sdo_nxt;
			sdo_oe_n_r <= sdo_oe_n_nxt;
			addr_r <= addr_nxt;
			mode_r <= mode_nxt;
			frame_r <= frame_nxt;
			fvalid_r <= fvalid_nxt;
			nvm_wr_r <= nvm_wr_nxt;
		end
	end

	always_comb
	begin
		o_sdo = 1'b0;
		o_sdo_oe_n = sdo_oe_n_r;
		o_sda_oe_n = 1'b1;
		o_i2c_addr = addr_r;
		o_i2c_mode = mode_r;
		o_frame = frame_r;
		o_frame_valid = fvalid_r;
		o_status = '{wiper: wiper_r, nvm: nvm_r, gain_mode: gain_r,
			busy: (state_r == ST_STORE)};
		o_input_reg = input_r;
		o_ab_setting = ab_r;
		o_wb_setting = wb_r;
		o_nvm_write = nvm_wr_r;
	end

	sequence s_short_frame;
		state_r == ST_SHIFT && frame_end && cnt_r != CNT_FULL;
	endsequence

	a_short_drop: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		s_short_frame |=> !fvalid_r)
		else $error("short frame was accepted");
	a_wp_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(!wp_n_s && !rst_fall) |=> $stable(wiper_r))
		else $error("wiper changed under write protect");
	a_reset_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		rst_fall |=> wiper_r == $past(nvm_r))
		else $error("reset did not reload wiper");
	a_ldw_copy: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(ldw_fall && wp_n_s && !rst_fall) |=> wiper_r == $past(input_r))
		else $error("load pin did not copy input register");
	a_gain_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(gain_r && !boot_r) |=> gain_r)
		else $error("gain mode was cleared");
	a_sdo_drain: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!o_sdo_oe_n |-> o_sdo == 1'b0)
		else $error("sdo drove high");
	a_store_lock: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state_r == ST_STORE) |=> state_r != ST_SHIFT)
		else $error("frame taken while storing");
	a_addr_map: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		dis_s |=> o_i2c_addr == {$past(sdo_pin_s), $past(sync_n_s)})
		else $error("address pins not sampled");
endmodule : digipot_control_pins
`default_nettype wire

// ===== core/digipot_pkg.sv
package digipot_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int FRAME_BITS = 16;
	localparam int CTRL_MSB = 15;
	localparam int CTRL_LSB = 12;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 8;
	localparam int DATA_MSB = 7;
	localparam int DATA_LSB = 0;
	localparam int STORE_TIME_US = 18_000;
	localparam int STORE_CYCLES = (STORE_TIME_US * (CLK_HZ / 1_000_000));
	localparam logic [7:0] WIPER_RST = 8'h80;
	localparam logic [7:0] INPUT_RST = 8'h00;
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_WR_INPUT = 4'h2;
	localparam logic [3:0] CMD_WR_WIPER = 4'h1;
	localparam logic [3:0] CMD_STORE = 4'h7;
	localparam logic [3:0] CMD_GAIN_OFF = 4'hD;
	localparam logic [3:0] CMD_READ = 4'h3;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_FULL = 5'h10;

	typedef struct packed
	{
		logic [3:0] ctrl;
		logic [3:0] addr;
		logic [7:0] data;
	} frame_s;

	typedef struct packed
	{
		logic [7:0] wiper;
		logic [7:0] nvm;
		logic gain_mode;
		logic busy;
	} status_s;
endpackage : digipot_pkg

// ===== core/digipot_sync.sv
`timescale 1ns/10ps
`default_nettype none
module digipot_sync
#(
	parameter int W = 1
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	always_comb
	begin
		meta_nxt = i_async;
		sync_nxt = meta_r;
	end

	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_r <= '1;
			sync_r <= '1;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign o_sync = sync_r;
endmodule : digipot_sync
`default_nettype wire

// ===== sim/digipot_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module digipot_host_model
(
	output logic o_sclk,
	output logic o_sync_n,
	output logic o_sdi
);
	initial
	begin
		o_sclk = 1'b1;
		o_sync_n = 1'b1;
		o_sdi = 1'b0;
	end

	// n falls of the clock, msb first; n below 16 makes a broken frame
	task automatic send(input logic [15:0] w, input int n);
		o_sync_n = 1'b0;
		#100;
		for (int i = 15; i > 15 - n; i--)
		begin
			o_sdi = w[i];
			#100;
			o_sclk = 1'b0;
			#100;
			o_sclk = 1'b1;
		end
		#100;
		o_sync_n = 1'b1;
		o_sdi = ~o_sdi;
	endtask : send
endmodule : digipot_host_model
`default_nettype wire

// ===== sim/digipot_control_pins_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			errors++; \
			$display("[ERR] %s expected %h seen %h", nm, e, g); \
		end \
	end
module digipot_control_pins_bench;
	import digipot_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_interface_select = 1'b0;
	logic i_reset_n = 1'b1;
	logic i_wp_n = 1'b1;
	logic i_independent_gain_mode = 1'b1;
	logic i_load_wiper_n = 1'b1;
	logic [7:0] i_nvm_wiper = 8'h5A;
	logic [7:0] i_nvm_ab = 8'h3C;
	logic [7:0] i_nvm_wb = 8'hC3;
	logic a0 = 1'b0;
	logic a1 = 1'b0;
	logic i_sclk, h_sync_n, i_sdi, o_sdo_oe_n, o_i2c_mode;
	logic o_frame_valid, o_nvm_write;
	logic [1:0] o_i2c_addr;
	logic [7:0] o_input_reg, o_ab_setting, o_wb_setting, d;
	frame_s o_frame;
	status_s o_status;
	wire logic i_sdo_pin;
	wire logic i_sync_n;
	int errors = 0;
	int checks_done = 0;
	int vcnt = 0;
	int ncnt = 0;
	int nvm;
	int wiper;
	int inp;

	// open-drain output with pull-up in spi, address strap in i2c
	assign i_sdo_pin = i_interface_select ? a1 : o_sdo_oe_n;
	assign i_sync_n = i_interface_select ? a0 : h_sync_n;
	always #12.5 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) if (o_frame_valid === 1'b1) vcnt++;
	always @(posedge i_sys_clk) if (o_nvm_write === 1'b1) ncnt++;

	digipot_host_model host (.o_sclk(i_sclk), .o_sync_n(h_sync_n),
		.o_sdi(i_sdi));
	digipot_control_pins dut (.i_sys_clk, .i_rst, .i_interface_select,
		.i_sclk, .i_sync_n, .i_sdi, .i_sdo_pin, .i_reset_n, .i_wp_n,
		.i_independent_gain_mode, .i_load_wiper_n, .i_nvm_wiper, .i_nvm_ab,
		.i_nvm_wb, .o_sdo(), .o_sdo_oe_n, .o_sda_oe_n(), .o_i2c_addr,
		.o_i2c_mode, .o_frame, .o_frame_valid, .o_status, .o_input_reg,
		.o_ab_setting, .o_wb_setting, .o_nvm_write);

	task automatic cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask : cyc

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// ok: 1 frame must be taken, 0 dropped, -1 not judged
	task automatic frame(input logic [15:0] w, input int n, input int ok);
		int v0;
		v0 = vcnt;
		host.send(w, n);
		for (int k = 0; k < 20 && vcnt == v0; k++)
			cyc(1);
		cyc(2);
		if (ok >= 0)
			`CHK("frame_count", ok, vcnt - v0)
		if (ok == 1)
			`CHK("frame", w, o_frame)
		if (ok == 1 && vcnt == v0)
			conclude();
	endtask : frame

	initial
	begin
		inp = $urandom(57);
		cyc(4);
		i_rst = 1'b0;
		cyc(6);
		wiper = i_nvm_wiper;
		nvm = i_nvm_wiper;
		inp = 0;
		`CHK("wiper_boot", wiper[7:0], o_status.wiper)
		`CHK("ab_gain", i_nvm_ab, o_ab_setting)
		`CHK("wb_gain", i_nvm_wb, o_wb_setting)
		`CHK("gain_mode", 1'b1, o_status.gain_mode)
		$display("test boot done");
		for (int t = 0; t < 4; t++)
		begin
			d = 8'($urandom);
			wiper = d;
			frame({CMD_WR_WIPER, 4'h0, d}, 16, 1);
			`CHK("wiper_wr", wiper[7:0], o_status.wiper)
		end
		`CHK("spi_mode", 1'b0, o_i2c_mode)
		frame({CMD_WR_WIPER, 4'h0, ~d}, 15, 0);
		`CHK("wiper_short", wiper[7:0], o_status.wiper)
		frame({CMD_GAIN_OFF, 4'h0, 8'h00}, 16, 1);
		`CHK("gain_kept", 1'b1, o_status.gain_mode)
		$display("test spi write done");
		d = 8'($urandom);
		inp = d;
		frame({CMD_WR_INPUT, 4'h0, d}, 16, 1);
		`CHK("input_reg", inp[7:0], o_input_reg)
		`CHK("wiper_held", wiper[7:0], o_status.wiper)
		i_load_wiper_n = 1'b0;
		cyc(8);
		i_load_wiper_n = 1'b1;
		cyc(6);
		wiper = inp;
		`CHK("wiper_load", wiper[7:0], o_status.wiper)
		$display("test load done");
		i_wp_n = 1'b0;
		cyc(4);
		frame({CMD_WR_WIPER, 4'h0, ~wiper[7:0]}, 16, -1);
		`CHK("wiper_wp", wiper[7:0], o_status.wiper)
		i_nvm_wiper = 8'($urandom);
		i_reset_n = 1'b0;
		cyc(8);
		i_reset_n = 1'b1;
		cyc(6);
		// reload takes the stored copy, not the power-up pins again
		wiper = nvm;
		`CHK("wiper_reload", wiper[7:0], o_status.wiper)
		i_wp_n = 1'b1;
		$display("test protect done");
		i_interface_select = 1'b1;
		for (int t = 0; t < 4; t++)
		begin
			{a1, a0} = 2'(t);
			cyc(6);
			`CHK("i2c_addr", 2'(t), o_i2c_addr)
			`CHK("i2c_mode", 1'b1, o_i2c_mode)
		end
		$display("test i2c done");
		i_interface_select = 1'b0;
		cyc(6);
		frame({CMD_STORE, 4'h0, 8'h00}, 16, 1);
		`CHK("store_pulse", 1, ncnt)
		`CHK("store_busy", 1'b1, o_status.busy)
		frame({CMD_WR_WIPER, 4'h0, ~wiper[7:0]}, 16, 0);
		`CHK("wiper_locked", wiper[7:0], o_status.wiper)
		$display("test store done");
		conclude();
	end
endmodule : digipot_control_pins_bench
`default_nettype wire
